// [rtcs_pkg.sv]
// Purpose: constants for the interrupt/status and timekeeping block
// Assumes: 40 MHz system clock, 8-bit register port from the serial engine
// Notes:   offsets are the byte addresses seen by the serial engine
package rtcs_pkg;
	// system clock
	localparam int unsigned CLK_HZ = 40000000;

	// register offsets
	localparam logic [7:0] ADDR_IRQ_CTRL_STATUS = 8'h01;
	localparam logic [7:0] ADDR_SECONDS         = 8'h02;
	localparam logic [7:0] ADDR_MINUTES         = 8'h03;
	localparam logic [7:0] ADDR_HOURS           = 8'h04;
	localparam logic [7:0] ADDR_DAY_OF_MONTH    = 8'h05;
	localparam logic [7:0] ADDR_DAY_OF_WEEK     = 8'h06;

	// interrupt_control_status field positions
	localparam int unsigned BIT_PULSE_SEL = 4;
	localparam int unsigned BIT_ALARM_FLAG = 3;
	localparam int unsigned BIT_CDOWN_FLAG = 2;
	localparam int unsigned BIT_ALARM_IE = 1;
	localparam int unsigned BIT_CDOWN_IE = 0;
	// seconds_and_integrity field position
	localparam int unsigned BIT_SUPPLY_LOW = 7;

	// reset values
	localparam logic       RST_SUPPLY_LOW = 1'b1;
	localparam logic [6:0] RST_SECONDS    = 7'h00;
	localparam logic [6:0] RST_MINUTES    = 7'h00;
	localparam logic [5:0] RST_HOURS      = 6'h00;
	localparam logic [5:0] RST_DAY        = 6'h01;
	localparam logic [2:0] RST_WEEKDAY    = 3'h0;

	// counting limits in packed bcd
	localparam logic [7:0] BCD_SEC_MAX  = 8'h59;
	localparam logic [7:0] BCD_MIN_MAX  = 8'h59;
	localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
	localparam logic [7:0] BCD_DAY_MIN  = 8'h01;
	localparam logic [2:0] WEEKDAY_MAX  = 3'h6;
	localparam logic [7:0] BCD_FEB      = 8'h02;

	// countdown source clock select codes
	localparam logic [1:0] SRC_4096HZ = 2'h0;
	localparam logic [1:0] SRC_64HZ   = 2'h1;
	localparam logic [1:0] SRC_1HZ    = 2'h2;
	localparam logic [1:0] SRC_1_60HZ = 2'h3;

	// pulse widths as reciprocal seconds, and derived cycle counts
	localparam int unsigned PULSE_RECIP_8192 = 8192;
	localparam int unsigned PULSE_RECIP_4096 = 4096;
	localparam int unsigned PULSE_RECIP_128  = 128;
	localparam int unsigned PULSE_RECIP_64   = 64;
	localparam int unsigned PULSE_CYC_8192 = CLK_HZ / PULSE_RECIP_8192;
	localparam int unsigned PULSE_CYC_4096 = CLK_HZ / PULSE_RECIP_4096;
	localparam int unsigned PULSE_CYC_128  = CLK_HZ / PULSE_RECIP_128;
	localparam int unsigned PULSE_CYC_64   = CLK_HZ / PULSE_RECIP_64;
	localparam int unsigned PULSE_CNT_W = 20;
endpackage

// [rtcs_core.sv]
// Purpose: interrupt flags, enables, interrupt pin and seconds-to-weekday counters
// Assumes: serial engine on the same clock; 1 Hz tick and supply pins asynchronous
// Notes:   months/years and alarm/countdown logic live outside and feed events in
`timescale 1ns/100ps
`default_nettype none

// Contract
// [RQ1] host writes zero to unused control bits
// [RQ2] level mode: interrupt follows countdown flag, enabled
// [RQ3] pulse mode pulses; alarm still holds interrupt
// [RQ4] alarm event sets alarm flag bit 3
// [RQ5] countdown end sets countdown flag bit 2
// [RQ6] flags stay set until host overwrites
// [RQ7] alarm flag: write 0 clears, 1 keeps
// [RQ8] countdown flag: write 0 clears, 1 keeps
// [RQ9] flag write is AND with current value
// [RQ10] interrupt is OR of enabled flags
// [RQ11] pulse width from source clock and count
// [RQ12] flag and interrupt rise together at count zero
// [RQ13] supply-low flag starts set, sets on faults
// [RQ14] supply-low flag cleared only by host write
// [RQ15] seconds packed bcd 00 to 59
// [RQ16] minutes packed bcd at 03h
// [RQ17] hours packed bcd at 04h
// [RQ18] day of month packed bcd at 05h
// [RQ19] february 29th when year divisible by four
// [RQ20] weekday 0 to 6 at 06h
// [RQ21] freeze counters during access, queue one tick
// [RQ22] tick carries seconds through weekday
module rtcs_core #(
	parameter int unsigned PULSE_CYC_8192 = rtcs_pkg::PULSE_CYC_8192,
	parameter int unsigned PULSE_CYC_4096 = rtcs_pkg::PULSE_CYC_4096,
	parameter int unsigned PULSE_CYC_128  = rtcs_pkg::PULSE_CYC_128,
	parameter int unsigned PULSE_CYC_64   = rtcs_pkg::PULSE_CYC_64
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// register port from the serial engine
	input  wire logic       access_active,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// asynchronous pins
	input  wire logic       tick_1hz_pin,
	input  wire logic       osc_stop_pin,
	input  wire logic       vdd_low_pin,
	// events and context from neighbouring logic
	input  wire logic       alarm_event,
	input  wire logic       countdown_done,
	input  wire logic [1:0] countdown_src_sel,
	input  wire logic       countdown_n_is_one,
	input  wire logic [7:0] month_bcd,
	input  wire logic [7:0] year_bcd,
	output logic            day_carry,
	// open-drain interrupt pin
	output logic            int_out,
	output logic            int_oe_n
);

	typedef struct packed {
		logic                              pulse_sel;
		logic                              alarm_flag;
		logic                              cdown_flag;
		logic                              alarm_ie;
		logic                              cdown_ie;
		logic                              supply_low;
		logic [6:0]                        sec;
		logic [6:0]                        min;
		logic [5:0]                        hour;
		logic [5:0]                        day;
		logic [2:0]                        wday;
		logic                              tick_pend;
		logic [1:0]                        tick_sync;
		logic                              tick_prev;
		logic [1:0]                        osc_sync;
		logic [1:0]                        vdd_sync;
		logic [rtcs_pkg::PULSE_CNT_W-1:0]  pulse_cnt;
		logic [7:0]                        rdata;
		logic                              int_act;
		logic                              day_carry;
	} rtcs_state_t;

	rtcs_state_t st_ff;
	rtcs_state_t nxt_st;

	// bcd increment with wrap to a given minimum
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] vmax,
		input logic [7:0] vmin);
		logic [7:0] r;
		r = 8'h00;
		if (v >= vmax) begin
			return {1'b1, vmin};
		end
		if (v[3:0] >= 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return {1'b0, r};
	endfunction

	// last day of the month in bcd
	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			rtcs_pkg::BCD_FEB: return leap ? 8'h29 : 8'h28; // [RQ19]
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// pulse length for the current countdown source
	function automatic logic [rtcs_pkg::PULSE_CNT_W-1:0] pulse_len(input logic [1:0] src,
		input logic n_one);
		case (src)
			rtcs_pkg::SRC_4096HZ: return n_one ? rtcs_pkg::PULSE_CNT_W'(PULSE_CYC_8192)
				: rtcs_pkg::PULSE_CNT_W'(PULSE_CYC_4096);
			rtcs_pkg::SRC_64HZ: return n_one ? rtcs_pkg::PULSE_CNT_W'(PULSE_CYC_128)
				: rtcs_pkg::PULSE_CNT_W'(PULSE_CYC_64);
			default: return rtcs_pkg::PULSE_CNT_W'(PULSE_CYC_64);
		endcase
	endfunction

	logic       tick_edge;
	logic       do_tick;
	logic [8:0] sec_n;
	logic [8:0] min_n;
	logic [8:0] hour_n;
	logic [8:0] day_n;
	logic       wr_ctl;
	logic       wr_sec;
	logic       pulse_on;

	always_comb begin
		nxt_st = st_ff;
		// second flop of each synchroniser is the only reader of the first
		nxt_st.tick_sync = {st_ff.tick_sync[0], tick_1hz_pin};
		nxt_st.osc_sync  = {st_ff.osc_sync[0], osc_stop_pin};
		nxt_st.vdd_sync  = {st_ff.vdd_sync[0], vdd_low_pin};
		nxt_st.tick_prev = st_ff.tick_sync[1];
		tick_edge = st_ff.tick_sync[1] & ~st_ff.tick_prev;

		wr_ctl = reg_wr && reg_addr == rtcs_pkg::ADDR_IRQ_CTRL_STATUS;
		wr_sec = reg_wr && reg_addr == rtcs_pkg::ADDR_SECONDS;

		// one tick is remembered while the host holds the counters
		do_tick = 1'b0;
		if (access_active) begin
			nxt_st.tick_pend = st_ff.tick_pend | tick_edge; // [RQ21]
		end else begin
			do_tick = st_ff.tick_pend | tick_edge; // [RQ21]
			nxt_st.tick_pend = 1'b0;
		end

		sec_n  = bcd_inc({1'b0, st_ff.sec}, rtcs_pkg::BCD_SEC_MAX, 8'h00); // [RQ15]
		min_n  = bcd_inc({1'b0, st_ff.min}, rtcs_pkg::BCD_MIN_MAX, 8'h00); // [RQ16]
		hour_n = bcd_inc({2'b00, st_ff.hour}, rtcs_pkg::BCD_HOUR_MAX, 8'h00); // [RQ17]
		day_n  = bcd_inc({2'b00, st_ff.day}, month_last(month_bcd, year_bcd),
			rtcs_pkg::BCD_DAY_MIN); // [RQ18] [RQ19]
		nxt_st.day_carry = 1'b0;
		if (do_tick) begin
			nxt_st.sec = sec_n[6:0]; // [RQ22]
			if (sec_n[8]) begin
				nxt_st.min = min_n[6:0]; // [RQ22]
				if (min_n[8]) begin
					nxt_st.hour = hour_n[5:0]; // [RQ22]
					if (hour_n[8]) begin
						nxt_st.day = day_n[5:0]; // [RQ22]
						nxt_st.day_carry = day_n[8];
						nxt_st.wday = (st_ff.wday >= rtcs_pkg::WEEKDAY_MAX) ? 3'h0
							: st_ff.wday + 3'h1; // [RQ20]
					end
				end
			end
		end

		// host writes to the time registers override the counting
		if (reg_wr) begin
			case (reg_addr)
				rtcs_pkg::ADDR_SECONDS:      nxt_st.sec  = reg_wdata[6:0]; // [RQ15]
				rtcs_pkg::ADDR_MINUTES:      nxt_st.min  = reg_wdata[6:0]; // [RQ16]
				rtcs_pkg::ADDR_HOURS:        nxt_st.hour = reg_wdata[5:0]; // [RQ17]
				rtcs_pkg::ADDR_DAY_OF_MONTH: nxt_st.day  = reg_wdata[5:0]; // [RQ18]
				rtcs_pkg::ADDR_DAY_OF_WEEK:  nxt_st.wday = reg_wdata[2:0]; // [RQ20]
				default: ;
			endcase
		end

		// unused upper control bits are simply not stored
		if (wr_ctl) begin // [RQ1]
			nxt_st.pulse_sel = reg_wdata[rtcs_pkg::BIT_PULSE_SEL];
			nxt_st.alarm_ie  = reg_wdata[rtcs_pkg::BIT_ALARM_IE];
			nxt_st.cdown_ie  = reg_wdata[rtcs_pkg::BIT_CDOWN_IE];
		end
		// flags: write ANDs, hardware set wins over a same-cycle clear
		nxt_st.alarm_flag = (wr_ctl ? st_ff.alarm_flag & reg_wdata[rtcs_pkg::BIT_ALARM_FLAG]
			: st_ff.alarm_flag) | alarm_event; // [RQ4] [RQ6] [RQ7] [RQ9]
		nxt_st.cdown_flag = (wr_ctl ? st_ff.cdown_flag & reg_wdata[rtcs_pkg::BIT_CDOWN_FLAG]
			: st_ff.cdown_flag) | countdown_done; // [RQ5] [RQ6] [RQ8] [RQ9]

		// supply-low: written value stored, faults force it set
		nxt_st.supply_low = (wr_sec ? reg_wdata[rtcs_pkg::BIT_SUPPLY_LOW] : st_ff.supply_low)
			| st_ff.osc_sync[1] | st_ff.vdd_sync[1]; // [RQ13] [RQ14]

		// pulse generator restarts on each countdown end
		if (countdown_done) begin
			nxt_st.pulse_cnt = pulse_len(countdown_src_sel, countdown_n_is_one); // [RQ11]
		end else if (st_ff.pulse_cnt != '0) begin
			nxt_st.pulse_cnt = st_ff.pulse_cnt - rtcs_pkg::PULSE_CNT_W'(1);
		end
		// pulse is on from the event cycle, so it registers with the flag
		pulse_on = countdown_done | (st_ff.pulse_cnt > rtcs_pkg::PULSE_CNT_W'(1)); // [RQ12]

		nxt_st.int_act = (nxt_st.alarm_flag & nxt_st.alarm_ie) // [RQ3] [RQ10]
			| (nxt_st.cdown_ie & (nxt_st.pulse_sel ? pulse_on // [RQ3] [RQ11]
			: nxt_st.cdown_flag)); // [RQ2] [RQ12]

		// read data is registered one cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				rtcs_pkg::ADDR_IRQ_CTRL_STATUS: nxt_st.rdata = {3'b000, st_ff.pulse_sel,
					st_ff.alarm_flag, st_ff.cdown_flag, st_ff.alarm_ie, st_ff.cdown_ie};
				rtcs_pkg::ADDR_SECONDS:      nxt_st.rdata = {st_ff.supply_low, st_ff.sec};
				rtcs_pkg::ADDR_MINUTES:      nxt_st.rdata = {1'b0, st_ff.min};
				rtcs_pkg::ADDR_HOURS:        nxt_st.rdata = {2'b00, st_ff.hour};
				rtcs_pkg::ADDR_DAY_OF_MONTH: nxt_st.rdata = {2'b00, st_ff.day};
				rtcs_pkg::ADDR_DAY_OF_WEEK:  nxt_st.rdata = {5'b00000, st_ff.wday};
				default:                     nxt_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff            <= '0;
			st_ff.supply_low <= rtcs_pkg::RST_SUPPLY_LOW; // [RQ13]
			st_ff.sec        <= rtcs_pkg::RST_SECONDS;
			st_ff.min        <= rtcs_pkg::RST_MINUTES;
			st_ff.hour       <= rtcs_pkg::RST_HOURS;
			st_ff.day        <= rtcs_pkg::RST_DAY;
			st_ff.wday       <= rtcs_pkg::RST_WEEKDAY;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign day_carry = st_ff.day_carry;
	// pin only ever pulls low; released means high impedance outside
	assign int_out   = 1'b0;
	assign int_oe_n  = ~st_ff.int_act;

endmodule // rtcs_core

`default_nettype wire

// [rtcs_core_chk.sv]
// Purpose: port-level checks for rtcs_core
// Assumes: host writes valid bcd only
// Notes:   flag checks need a quiet cycle between event and read
`timescale 1ns/100ps
`default_nettype none
module rtcs_core_chk (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// events and pins
	input wire logic       vdd_low_pin,
	input wire logic       alarm_event,
	input wire logic       countdown_done,
	input wire logic       day_carry,
	input wire logic       int_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_at(logic [7:0] a); reg_rd && reg_addr == a; endsequence
	sequence quiet; !reg_wr; endsequence
	alarm_set_a: assert property (alarm_event ##1 quiet ##1 rd_at(8'h01) |=> reg_rdata[3])
		else $error("alarm flag not set");
	cdown_set_a: assert property (countdown_done ##1 quiet ##1 rd_at(8'h01) |=> reg_rdata[2])
		else $error("countdown flag not set");
	alarm_clr_a: assert property ((reg_wr && reg_addr == 8'h01 && !reg_wdata[3] && !alarm_event)
		##1 (!reg_wr && !alarm_event) ##1 rd_at(8'h01) |=> !reg_rdata[3]) else $error("alarm not cleared");
	cdown_clr_a: assert property ((reg_wr && reg_addr == 8'h01 && !reg_wdata[2] && !countdown_done)
		##1 (!reg_wr && !countdown_done) ##1 rd_at(8'h01) |=> !reg_rdata[2]) else $error("cdown kept");
	supply_low_a: assert property (vdd_low_pin [*5] ##1 rd_at(8'h02) |=> reg_rdata[7])
		else $error("supply-low flag not set");
	sec_bcd_a: assert property (rd_at(8'h02) |=> reg_rdata[6:4] <= 3'h5 && reg_rdata[3:0] <= 4'h9)
		else $error("seconds out of range");
	hour_bcd_a: assert property (rd_at(8'h04) |=> reg_rdata <= 8'h23 && reg_rdata[3:0] <= 4'h9)
		else $error("hours out of range");
	wday_range_a: assert property (rd_at(8'h06) |=> reg_rdata <= 8'h06)
		else $error("weekday out of range");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without strobe");
	irq_cause_a: assert property ($fell(int_oe_n) |-> $past(alarm_event || countdown_done || reg_wr))
		else $error("interrupt without cause");
	carry_pulse_a: assert property (day_carry |=> !day_carry)
		else $error("day carry too long");
endmodule // rtcs_core_chk
`default_nettype wire

// [rtcs_host.sv]
// Purpose: serial-engine side model of the register port
// Assumes: one byte per strobe
// Notes:   released lines show inverted values so stale data cannot match
`timescale 1ns/100ps
`default_nettype none
module rtcs_host (
	// clock
	input  wire logic       clock,
	// register port
	output logic            access_active,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		access_active = 1'b0;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= (a == 8'h01) ? (d & 8'h1f) : d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~reg_wdata;
		reg_addr <= ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
	// long holds are the caller's choice; keep them under a second
	task automatic hold(input logic v);
		@(posedge clock);
		access_active <= v;
	endtask
endmodule // rtcs_host
`default_nettype wire

// [rtcs_core_tb_top.sv]
// Purpose: self-checking bench for rtcs_core
// Assumes: shortened pulse widths 3/5/8/10
// Notes:   tick pin stays low between bursts
`timescale 1ns/100ps
`default_nettype none
module rtcs_core_tb_top;
	logic       clock, rst, access_active, reg_wr, reg_rd, tick, osc_stop, vdd_low;
	logic       alarm_ev, cd_done, n_one, day_carry, int_out, int_oe_n;
	logic [1:0] src;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, year, month, v;
	int         err_count, samples_checked, carries;
	rtcs_core #(.PULSE_CYC_8192(3), .PULSE_CYC_4096(5), .PULSE_CYC_128(8), .PULSE_CYC_64(10))
	i_rtcs_core (.clock(clock), .rst(rst), .access_active(access_active), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tick_1hz_pin(tick), .osc_stop_pin(osc_stop), .vdd_low_pin(vdd_low),
		.alarm_event(alarm_ev), .countdown_done(cd_done), .countdown_src_sel(src),
		.countdown_n_is_one(n_one), .month_bcd(month), .year_bcd(year),
		.day_carry(day_carry), .int_out(int_out), .int_oe_n(int_oe_n));
	rtcs_host i_rtcs_host (.clock(clock), .access_active(access_active), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// counted on the falling edge so the one-cycle pulse is settled
	always @(negedge clock) if (day_carry === 1'b1) carries++;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
		i_rtcs_host.rd(a, v);
		chk(nm, e, v);
	endtask
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic pulse(input logic a);
		@(posedge clock);
		alarm_ev <= a;
		cd_done <= ~a;
		@(posedge clock);
		alarm_ev <= 1'b0;
		cd_done <= 1'b0;
		#1;
	endtask
	// 200 ns period, only inside a burst
	task automatic tick_burst;
		@(posedge clock);
		tick <= 1'b1;
		repeat (4) @(posedge clock);
		tick <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task automatic t_reset;
		logic [7:0] e [8];
		e = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) rc("reset", 8'(i), e[i]);
	endtask
	task automatic t_flags;
		i_rtcs_host.wr(8'h01, 8'h03);
		pulse(1'b1);
		chk("int alarm", 8'h00, {7'h0, int_oe_n});
		chk("int data", 8'h00, {7'h0, int_out});
		pulse(1'b0);
		rc("flags", 8'h01, 8'h0f);
		i_rtcs_host.wr(8'h01, 8'h07);
		rc("and write", 8'h01, 8'h07);
		chk("int level", 8'h00, {7'h0, int_oe_n});
		i_rtcs_host.wr(8'h01, 8'h03);
		rc("cleared", 8'h01, 8'h03);
		chk("int off", 8'h01, {7'h0, int_oe_n});
	endtask
	task automatic t_pulse;
		logic [2:0] s [5];
		int         w [5];
		int         n;
		s = '{3'h1, 3'h0, 3'h3, 3'h4, 3'h7};
		w = '{3, 5, 8, 10, 10};
		i_rtcs_host.wr(8'h01, 8'h11);
		for (int i = 0; i < 5; i++) begin
			src <= s[i][2:1];
			n_one <= s[i][0];
			pulse(1'b0);
			n = 0;
			while (int_oe_n === 1'b0 && n < 50) begin
				@(posedge clock);
				#1 n++;
			end
			chk("pulse width", 8'(w[i]), 8'(n));
		end
		i_rtcs_host.wr(8'h01, 8'h12);
		pulse(1'b1);
		repeat (20) @(posedge clock);
		chk("alarm held", 8'h00, {7'h0, int_oe_n});
		i_rtcs_host.wr(8'h01, 8'h00);
	endtask
	task automatic t_day(input logic [7:0] m, input logic [7:0] y, input logic [7:0] d,
		input logic [7:0] ed);
		logic [7:0] s [5];
		logic [7:0] e [5];
		int         c0;
		s = '{8'h59, 8'h59, 8'h23, d, 8'h06};
		e = '{8'h00, 8'h00, 8'h00, ed, 8'h00};
		c0 = carries;
		@(posedge clock);
		year <= y;
		month <= m;
		for (int i = 0; i < 5; i++) i_rtcs_host.wr(8'(i + 2), s[i]);
		tick_burst();
		for (int i = 0; i < 5; i++) rc("time", 8'(i + 2), e[i]);
		chk("carry", {7'h0, ed == 8'h01}, 8'(carries - c0));
	endtask
	task automatic t_freeze;
		i_rtcs_host.hold(1'b1);
		tick_burst();
		tick_burst();
		rc("frozen", 8'h02, 8'h00);
		i_rtcs_host.hold(1'b0);
		repeat (2) @(posedge clock);
		rc("queued", 8'h02, 8'h01);
	endtask
	task automatic t_supply;
		for (int i = 0; i < 2; i++) begin
			i_rtcs_host.wr(8'h02, 8'h00);
			rc("vl clear", 8'h02, 8'h00);
			{osc_stop, vdd_low} <= 2'(i + 1);
			repeat (6) @(posedge clock);
			rc("vl set", 8'h02, 8'h80);
			{osc_stop, vdd_low} <= 2'h0;
			repeat (6) @(posedge clock);
			rc("vl kept", 8'h02, 8'h80);
		end
	endtask
	initial begin
		rst = 1'b1;
		{tick, osc_stop, vdd_low, alarm_ev, cd_done, n_one} = 6'h00;
		src = 2'h0;
		year = 8'h00;
		month = 8'h02;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_flags();
		t_pulse();
		t_day(8'h02, 8'h00, 8'h28, 8'h29);
		t_day(8'h02, 8'h01, 8'h28, 8'h01);
		t_day(8'h04, 8'h01, 8'h30, 8'h01);
		t_freeze();
		t_supply();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		end_of_test();
	end
endmodule // rtcs_core_tb_top
bind rtcs_core rtcs_core_chk i_rtcs_core_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.vdd_low_pin(vdd_low_pin), .alarm_event(alarm_event), .countdown_done(countdown_done),
	.day_carry(day_carry), .int_oe_n(int_oe_n));
`default_nettype wire
